// [core/udr_params.svh]
// Offsets, field positions, reset values and widths of the USB device
// address and interrupt register block.
// Assumes byte addresses on a plain register port with 32-bit data.
`ifndef UDR_PARAMS_SVH
`define UDR_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define UDR_ADDR_W        8
`define UDR_OFF_GLB       8'h04
`define UDR_OFF_FADDR     8'h08
`define UDR_OFF_IER       8'h10
`define UDR_OFF_IDR       8'h14
`define UDR_OFF_IMR       8'h18
`define UDR_OFF_ISR       8'h1c
`define UDR_OFF_ICR       8'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UDR_GLB_ADDR_ST   0
`define UDR_GLB_CONFIG    1
`define UDR_GLB_RES_SEND  2
`define UDR_GLB_RES_SEEN  3
`define UDR_GLB_RWAKE     4
`define UDR_FA_ENABLE     8
`define UDR_EVT_LSB       8
`define UDR_NUM_EP        4
`define UDR_NUM_CAUSE     5
`define UDR_NUM_EVT       6

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define UDR_GLB_RESET     5'h10
`define UDR_FADDR_RESET   7'h00
`define UDR_FEN_RESET     1'h1
`define UDR_MASK_VALID    16'h2f0f
`define UDR_MASK_RESET    16'h0200

`endif

// [core/udr_pkg.sv]
// Types shared by the USB device address and interrupt register block.
// Assumes the constants of udr_params.svh beside it.
package udr_pkg;

    // Interrupt vector laid out as the enable, mask and status registers.
    typedef logic [15:0] udr_irq_vec_t;

    // Index of each bus event flag, counted from status bit eight.
    typedef enum logic [2:0] {
        UDR_EV_SUSPEND,
        UDR_EV_BUS_RESUME,
        UDR_EV_EXT_RESUME,
        UDR_EV_FRAME_START,
        UDR_EV_RESET_DONE,
        UDR_EV_WAKEUP
    } udr_event_t;

endpackage

// [core/udr_regs.sv]
// Address, global state and interrupt registers of a full-speed USB device.
// Assumes a bus engine on i_ref_clk giving one-cycle event pulses, endpoint
// control registers outside giving their cause bits as levels, and a raw
// asynchronous send-resume pin.
//
// Notes on behaviour
// - Drive K-state when remote wake and resume-send set.
// - Seven-bit address, zero after any reset.
// - Function enable gates data packet transfer.
// - Enable register writes set mask bits.
// - Disable register writes clear mask bits.
// - Mask register reads current enables.
// - Bus resume mask resets enabled.
// - Endpoint flag raised by any endpoint cause.
// - Endpoint flag holds until endpoint cause cleared.
// - Bus-reset-done flag at bit twelve, unmaskable position.
// - Clear register ones clear bus event flags.
// - Resume-send enable arms remote wake and pin.
`timescale 1ns/1ps
`include "udr_params.svh"

module udr_regs
(
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_reset,
    input  wire logic [`UDR_ADDR_W-1:0] i_addr,
    input  wire logic [31:0]            i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic      [31:0]            o_rdata,
    input  wire logic [19:0]            i_ep_cause,
    input  wire logic                   i_suspend_evt,
    input  wire logic                   i_bus_resume_evt,
    input  wire logic                   i_frame_start_evt,
    input  wire logic                   i_bus_reset_done_evt,
    input  wire logic                   i_wakeup_evt,
    input  wire logic                   i_suspended,
    input  wire logic                   i_resume_seen,
    input  wire logic                   i_send_resume,
    output logic                        o_drive_k,
    output logic      [6:0]             o_device_bus_address,
    output logic                        o_function_enable,
    output logic                        o_address_state,
    output logic                        o_configured,
    output logic                        o_irq
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [4:0]              glb_ff;       // Global state bits.
    logic [4:0]              nxt_glb;      // Next global state.
    logic [6:0]              addr_ff;      // Device bus address.
    logic [6:0]              nxt_addr;     // Next device bus address.
    logic                    fen_ff;       // Function enable.
    logic                    nxt_fen;      // Next function enable.
    udr_pkg::udr_irq_vec_t   mask_ff;      // Interrupt enables.
    udr_pkg::udr_irq_vec_t   nxt_mask;     // Next interrupt enables.
    logic [5:0]              evt_ff;       // Sticky bus event flags.
    logic [5:0]              nxt_evt;      // Next bus event flags.
    logic [3:0]              ep_flag_ff;   // Endpoint flags.
    logic [3:0]              nxt_ep_flag;  // Next endpoint flags.
    logic [1:0]              pin_sync_ff;  // Send-resume pin synchroniser.
    logic                    pin_last_ff;  // Previous synchronised pin level.
    logic [31:0]             rdata_ff;     // Read data register.
    logic [31:0]             nxt_rdata;    // Next read data.
    logic                    drive_k_ff;   // K-state request.
    logic                    irq_ff;       // Interrupt line.
    logic                    nxt_drive_k;  // Next K-state request.
    logic                    nxt_irq;      // Next interrupt line.
    udr_pkg::udr_irq_vec_t   status;       // Current status view.
    udr_pkg::udr_irq_vec_t   nxt_status;   // Status after this edge.
    logic [5:0]              evt_set;      // Event pulses this cycle.
    logic                    ext_rise;     // Qualified send-resume edge.
    logic                    wr_hit_glb;   // Write to global state.
    logic                    wr_hit_fa;    // Write to function address.
    logic                    rd_hit_isr;   // Read of status register.

    assign wr_hit_glb = i_wr && (i_addr == `UDR_OFF_GLB);
    assign wr_hit_fa  = i_wr && (i_addr == `UDR_OFF_FADDR);
    assign rd_hit_isr = i_rd && (i_addr == `UDR_OFF_ISR);
    assign status     = {2'h0, evt_ff, 4'h0, ep_flag_ff};

    // ------------------------------------------------------------------
    // Send-resume pin
    // ------------------------------------------------------------------

    // Two stages tame the asynchronous pin; only the second is read.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            pin_sync_ff <= 2'h0;
            pin_last_ff <= 1'h0;
        end
        else
        begin
            pin_sync_ff <= {pin_sync_ff[0], i_send_resume};
            pin_last_ff <= pin_sync_ff[1];
        end
    end

    // A rising edge counts only in suspend and with resume-send enabled.
    assign ext_rise = pin_sync_ff[1] && !pin_last_ff && i_suspended
                      && glb_ff[`UDR_GLB_RES_SEND];

    // ------------------------------------------------------------------
    // Global state and function address
    // ------------------------------------------------------------------

    // Software writes; address state may only be set, never cleared.
    always_comb
    begin
        nxt_glb  = glb_ff;
        nxt_addr = addr_ff;
        nxt_fen  = fen_ff;
        if (wr_hit_glb)
        begin
            nxt_glb[`UDR_GLB_ADDR_ST]  = glb_ff[`UDR_GLB_ADDR_ST]
                                         | i_wdata[`UDR_GLB_ADDR_ST];
            nxt_glb[`UDR_GLB_CONFIG]   = i_wdata[`UDR_GLB_CONFIG];
            nxt_glb[`UDR_GLB_RES_SEND] = i_wdata[`UDR_GLB_RES_SEND];
            nxt_glb[`UDR_GLB_RWAKE]    = i_wdata[`UDR_GLB_RWAKE];
        end
        // The resume-seen bit mirrors the bus engine.
        nxt_glb[`UDR_GLB_RES_SEEN] = i_resume_seen;
        if (wr_hit_fa)
        begin
            nxt_addr = i_wdata[6:0];
            nxt_fen  = i_wdata[`UDR_FA_ENABLE];
        end
        // K-state follows both enables as they stand after this edge.
        nxt_drive_k = nxt_glb[`UDR_GLB_RWAKE] & nxt_glb[`UDR_GLB_RES_SEND];
    end

    // Registers the state; K-state follows both enables.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            glb_ff     <= `UDR_GLB_RESET;
            addr_ff    <= `UDR_FADDR_RESET;
            fen_ff     <= `UDR_FEN_RESET;
            drive_k_ff <= 1'h0;
        end
        else
        begin
            glb_ff     <= nxt_glb;
            addr_ff    <= nxt_addr;
            fen_ff     <= nxt_fen;
            drive_k_ff <= nxt_drive_k;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt mask
    // ------------------------------------------------------------------

    // Enable sets, disable clears; bit twelve never exists.
    always_comb
    begin
        nxt_mask = mask_ff;
        if (i_wr && (i_addr == `UDR_OFF_IER))
        begin
            nxt_mask = mask_ff | (i_wdata[15:0] & `UDR_MASK_VALID);
        end
        else if (i_wr && (i_addr == `UDR_OFF_IDR))
        begin
            nxt_mask = mask_ff & ~i_wdata[15:0];
        end
    end

    // Registers the mask; bus resume starts enabled.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            mask_ff <= `UDR_MASK_RESET;
        end
        else
        begin
            mask_ff <= nxt_mask;
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------

    // One flag per endpoint follows the OR of its held causes.
    genvar ep;
    generate
        for (ep = 0; ep < `UDR_NUM_EP; ep++)
        begin : g_ep
            assign nxt_ep_flag[ep] =
                |i_ep_cause[ep*`UDR_NUM_CAUSE +: `UDR_NUM_CAUSE];
        end
    endgenerate

    assign evt_set = {i_wakeup_evt | ext_rise, i_bus_reset_done_evt,
                      i_frame_start_evt, ext_rise, i_bus_resume_evt,
                      i_suspend_evt};

    // Clear by the clear register or a status read; a new event wins.
    always_comb
    begin
        nxt_evt = evt_ff;
        if (i_wr && (i_addr == `UDR_OFF_ICR))
        begin
            nxt_evt = evt_ff & ~i_wdata[`UDR_EVT_LSB +: `UDR_NUM_EVT];
        end
        else if (rd_hit_isr)
        begin
            nxt_evt = 6'h00;
        end
        nxt_evt    = nxt_evt | evt_set;
        nxt_status = {2'h0, nxt_evt, 4'h0, nxt_ep_flag};
        nxt_irq    = |(nxt_status & nxt_mask);
    end

    // Registers the flags and the interrupt line.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            evt_ff     <= 6'h00;
            ep_flag_ff <= 4'h0;
            irq_ff     <= 1'h0;
        end
        else
        begin
            evt_ff     <= nxt_evt;
            ep_flag_ff <= nxt_ep_flag;
            irq_ff     <= nxt_irq;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------

    // Write-only and unmapped offsets read as zero.
    always_comb
    begin
        nxt_rdata = 32'h0;
        if (i_rd)
        begin
            case (i_addr)
                `UDR_OFF_GLB:   nxt_rdata = {27'h0, glb_ff};
                `UDR_OFF_FADDR: nxt_rdata = {23'h0, fen_ff, 1'h0, addr_ff};
                `UDR_OFF_IMR:   nxt_rdata = {16'h0, mask_ff};
                `UDR_OFF_ISR:   nxt_rdata = {16'h0, status};
                default:        nxt_rdata = 32'h0;
            endcase
        end
    end

    // Holds read data for the one cycle after the strobe.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            rdata_ff <= 32'h0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_rdata              = rdata_ff;
    assign o_drive_k            = drive_k_ff;
    assign o_device_bus_address = addr_ff;
    assign o_function_enable    = fen_ff;
    assign o_address_state      = glb_ff[`UDR_GLB_ADDR_ST];
    assign o_configured         = glb_ff[`UDR_GLB_CONFIG];
    assign o_irq                = irq_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    kstate_drive_a: assert property (wr_hit_glb && i_wdata[4] && i_wdata[2]
        |=> o_drive_k) else $error("K-state not driven");
    addr_reset_a: assert property ($past(i_reset) |-> addr_ff == 7'h0)
        else $error("Address not zero after reset");
    fen_clear_a: assert property (wr_hit_fa && !i_wdata[8]
        |=> !o_function_enable) else $error("Function enable not cleared");
    enable_set_a: assert property (i_wr && i_addr == 8'h10
        |=> ((mask_ff & $past(i_wdata[15:0]) & 16'h2f0f)
             == ($past(i_wdata[15:0]) & 16'h2f0f))) else $error("Enable lost");
    disable_clr_a: assert property (i_wr && i_addr == 8'h14
        |=> (mask_ff & $past(i_wdata[15:0])) == 16'h0) else $error("Disable lost");
    mask_read_a: assert property (i_rd && i_addr == 8'h18
        |=> o_rdata == {16'h0, $past(mask_ff)}) else $error("Mask read wrong");
    resume_mask_a: assert property ($past(i_reset) |-> mask_ff[9])
        else $error("Bus resume mask not enabled");
    ep_flag_a: assert property (|i_ep_cause[4:0] |=> status[0])
        else $error("Endpoint flag not raised");
    no_mask12_a: assert property (!mask_ff[12])
        else $error("Mask bit twelve set");
    clear_susp_a: assert property (i_wr && i_addr == 8'h20 && i_wdata[8]
        && !i_suspend_evt |=> !evt_ff[0]) else $error("Suspend flag not cleared");
    irq_level_a: assert property (o_irq == |(status & mask_ff))
        else $error("Interrupt line wrong");
    irq_event_a: assert property (i_frame_start_evt && mask_ff[11]
        && !(i_wr && i_addr == 8'h14) |=> o_irq) else $error("Interrupt not raised");

endmodule // udr_regs

// [testbench/testbench.sv]
// Self-checking bench for the address and interrupt register block.
// Assumes udr_regs and the host model are compiled before it.
`timescale 1ns/1ps
`include "udr_params.svh"

module testbench;
    logic        i_ref_clk;
    logic        i_reset;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [31:0] o_rdata;
    logic [19:0] ep_cause;
    logic [4:0]  evt;
    logic        susp;
    logic        pin;
    logic        o_drive_k;
    logic [6:0]  o_addr;
    logic        o_fen;
    logic        o_irq;
    logic        o_addr_st;
    logic        o_cfg;
    logic [31:0] d;
    int          fails;
    int          checks_done;

    udr_host_model u_host (.i_ref_clk(i_ref_clk), .o_ep_cause(ep_cause), .o_evt(evt),
        .o_suspended(susp), .o_send_resume(pin));

    udr_regs u_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_ep_cause(ep_cause), .i_suspend_evt(evt[0]), .i_bus_resume_evt(evt[1]),
        .i_frame_start_evt(evt[2]), .i_bus_reset_done_evt(evt[3]),
        .i_wakeup_evt(evt[4]), .i_suspended(susp), .i_resume_seen(1'h0),
        .i_send_resume(pin), .o_drive_k(o_drive_k), .o_device_bus_address(o_addr),
        .o_function_enable(o_fen), .o_address_state(o_addr_st), .o_configured(o_cfg),
        .o_irq(o_irq));

    // -------------------------------------------------------------
    // Bus and checking tasks
    // -------------------------------------------------------------
    // A write is one strobed cycle.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_ref_clk);
        i_wr <= 1'h1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_ref_clk);
        i_wr <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a);
        @(posedge i_ref_clk);
        i_rd <= 1'h1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'h0;
        #1;
        d = o_rdata;
    endtask

    // Counts every comparison and reports a mismatch at once.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Lets a number of edges pass and settles after the last one.
    task automatic idle(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    // Reset values, address fields and unmapped places.
    task automatic t_address();
        rd(`UDR_OFF_FADDR);
        chk("faddr reset", d, 32'h00000100);
        rd(`UDR_OFF_IMR);
        chk("mask reset", d, 32'h00000200);
        wr(`UDR_OFF_FADDR, 32'h0000007f);
        rd(`UDR_OFF_FADDR);
        chk("faddr", d, 32'h0000007f);
        chk("fen pin", {31'h0, o_fen}, 32'h0);
        chk("addr pin", {25'h0, o_addr}, 32'h7f);
        wr(`UDR_OFF_FADDR, 32'hffffffff);
        rd(`UDR_OFF_FADDR);
        chk("faddr full", d, 32'h0000017f);
        rd(8'h0c);
        chk("unmapped", d, 32'h0);
        rd(`UDR_OFF_IER);
        chk("ier read", d, 32'h0);
        $display("test address done");
    endtask

    // Enable and disable writes touch only the ones written.
    task automatic t_mask();
        wr(`UDR_OFF_IER, 32'hffffffff);
        rd(`UDR_OFF_IMR);
        chk("mask all", d, 32'h00002f0f);
        wr(`UDR_OFF_IDR, 32'h00000f0e);
        rd(`UDR_OFF_IMR);
        chk("mask some", d, 32'h00002001);
        wr(`UDR_OFF_IDR, 32'hffffffff);
        rd(`UDR_OFF_IMR);
        chk("mask none", d, 32'h0);
        $display("test mask done");
    endtask

    // Each clear bit but the external-resume one removes only its own flag; a read clears the rest.
    task automatic t_events();
        int pos[5] = '{8, 9, 11, 12, 13};
        for (int i = 0; i < 5; i++)
        begin
            u_host.pulse(5'h1f);
            wr(`UDR_OFF_ICR, 32'h1 << pos[i]);
            rd(`UDR_OFF_ISR);
            chk("clear one", d, 32'h3b00 & ~(32'h1 << pos[i]));
            rd(`UDR_OFF_ISR);
            chk("read clear", d, 32'h0);
        end
        wr(`UDR_OFF_IER, 32'h00000800);
        u_host.pulse(5'h01);
        idle(1);
        chk("irq masked", {31'h0, o_irq}, 32'h0);
        u_host.pulse(5'h04);
        idle(1);
        chk("irq frame", {31'h0, o_irq}, 32'h1);
        wr(`UDR_OFF_ICR, 32'h00000800);
        idle(2);
        chk("irq cleared", {31'h0, o_irq}, 32'h0);
        rd(`UDR_OFF_ISR);
        $display("test events done");
    endtask

    // Every cause of every endpoint raises its flag while it stands.
    task automatic t_endpoints();
        wr(`UDR_OFF_IER, 32'h0000000f);
        for (int j = 0; j < 20; j++)
        begin
            u_host.set_cause(20'h1 << j);
            idle(2);
            rd(`UDR_OFF_ISR);
            chk("ep flag", d, 32'h1 << (j / 5));
            chk("ep irq", {31'h0, o_irq}, 32'h1);
            rd(`UDR_OFF_ISR);
            chk("ep sticky", d, 32'h1 << (j / 5));
            u_host.set_cause(20'h0);
            idle(2);
            rd(`UDR_OFF_ISR);
            chk("ep gone", d, 32'h0);
        end
        $display("test endpoints done");
    endtask

    // K-state needs both enables; the pin raises two flags in suspend.
    task automatic t_wake();
        chk("k reset", {31'h0, o_drive_k}, 32'h0);
        wr(`UDR_OFF_GLB, 32'h00000014);
        idle(2);
        chk("k on", {31'h0, o_drive_k}, 32'h1);
        rd(`UDR_OFF_GLB);
        chk("glb", d, 32'h00000014);
        wr(`UDR_OFF_GLB, 32'h00000004);
        idle(2);
        chk("k off", {31'h0, o_drive_k}, 32'h0);
        u_host.set_pin(1'h1, 1'h0);
        u_host.set_pin(1'h1, 1'h1);
        idle(6);
        rd(`UDR_OFF_ISR);
        chk("ext resume", d, 32'h00002400);
        u_host.set_pin(1'h0, 1'h0);
        $display("test wake done");
    endtask

    // Address state is set-only; a mid-run reset restores the address, mask and global state reset values.
    task automatic t_reset();
        wr(`UDR_OFF_GLB, 32'h00000003);
        idle(1);
        chk("addr state", {31'h0, o_addr_st}, 32'h1);
        chk("configured", {31'h0, o_cfg}, 32'h1);
        wr(`UDR_OFF_GLB, 32'h00000000);
        rd(`UDR_OFF_GLB);
        chk("addr state kept", d, 32'h00000001);
        @(posedge i_ref_clk);
        i_reset <= 1'h1;
        repeat (3) @(posedge i_ref_clk);
        i_reset <= 1'h0;
        rd(`UDR_OFF_FADDR);
        chk("faddr rerun", d, 32'h00000100);
        rd(`UDR_OFF_IMR);
        chk("mask rerun", d, 32'h00000200);
        rd(`UDR_OFF_GLB);
        chk("glb rerun", d, 32'h00000010);
        chk("cfg rerun", {31'h0, o_cfg}, 32'h0);
        chk("addr state rerun", {31'h0, o_addr_st}, 32'h0);
        $display("test reset done");
    endtask

    // -------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // -------------------------------------------------------------
    initial
    begin
        i_ref_clk = 1'h0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    // A hang counts as a mismatch and ends the run.
    initial
    begin
        #200us;
        fails++;
        complete_run();
    end

    initial
    begin
        fails = 0;
        checks_done = 0;
        i_reset = 1'h1;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        i_wr = 1'h0;
        i_rd = 1'h0;
        repeat (10) @(posedge i_ref_clk);
        i_reset <= 1'h0;
        t_address();
        t_wake();
        t_mask();
        t_reset();
        t_events();
        t_endpoints();
        complete_run();
    end
endmodule // testbench

// [testbench/udr_host_model.sv]
// Behavioural bus engine facing the register block: event pulses,
// endpoint cause levels, the suspend level and the send-resume pin.
// Assumes the bench calls its tasks one after another from one process.
`timescale 1ns/1ps

module udr_host_model
(
    input  wire logic        i_ref_clk,
    output logic      [19:0] o_ep_cause,
    output logic      [4:0]  o_evt,
    output logic             o_suspended,
    output logic             o_send_resume
);
    // -------------------------------------------------------------
    // Stimulus tasks
    // -------------------------------------------------------------
    // Event pulses stand for exactly one cycle.
    task automatic pulse(input logic [4:0] mask);
        @(posedge i_ref_clk);
        o_evt <= mask;
        @(posedge i_ref_clk);
        o_evt <= 5'h00;
    endtask

    // Cause levels stay until the endpoint side clears them.
    task automatic set_cause(input logic [19:0] v);
        @(posedge i_ref_clk);
        o_ep_cause <= v;
    endtask

    // The pin is driven after an edge, like every other input.
    task automatic set_pin(input logic susp, input logic pin);
        @(posedge i_ref_clk);
        o_suspended   <= susp;
        o_send_resume <= pin;
    endtask

    // Everything starts idle.
    initial
    begin
        o_ep_cause    = 20'h00000;
        o_evt         = 5'h00;
        o_suspended   = 1'h0;
        o_send_resume = 1'h0;
    end
endmodule // udr_host_model
